// ===== src/rsq_pkg.sv
// reset sequencer constants, encodings and carrier types
// assumes one 10 mhz clock that is the on-chip rc oscillator
package rsq_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_START_NS  = 4000;
  // least time: round up to whole cycles
  localparam int OSC_START_CYC =
    (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC      = 66;
  localparam int XTAL_HOLD_DEF = 5000;
  localparam int CNT_W         = 13;

  // ==========================================================
  // register map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] CAUSE_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] CFG_OFS   = 8'h04;
  localparam logic [AXI_AW-1:0] ISTS_OFS  = 8'h08;
  localparam logic [AXI_AW-1:0] IMSK_OFS  = 8'h0c;

  localparam int STOP_BIT = 7;
  localparam int WDT_BIT  = 6;
  localparam int EXT_BIT  = 5;
  localparam int XTAL_BIT = 0;

  localparam int EV_W    = 4;
  localparam int EV_REL  = 0;
  localparam int EV_WDT  = 1;
  localparam int EV_PIN  = 2;
  localparam int EV_STOP = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // reset vector
  localparam logic [15:0] VEC_HI_ADDR = 16'h0002;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0003;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_START  = 3'h0,
    ST_SUPPLY = 3'h1,
    ST_HOLD   = 3'h3,
    ST_PINW   = 3'h2,
    ST_VHI    = 3'h6,
    ST_VLO    = 3'h7,
    ST_LOAD   = 3'h5,
    ST_RUN    = 3'h4
  } rsq_phase_type;

  typedef struct packed {
    logic por;
    logic lvd;
    logic supply_ok;
    logic pin_rst_n;
    logic wdt_to;
    logic stop_rec;
    logic stop_by_pin;
    logic stop_by_wdt;
  } rsq_src_type;

  localparam rsq_src_type SRC_IDLE = 8'h10;

  typedef struct packed {
    logic              cpu_rst_n;
    logic              periph_idle;
    logic              gpio_park;
    logic              ctrl_load;
    logic              wdt_osc_load;
    logic              clk_sel_rc;
    logic              cpu_run;
    logic              pmem_rd;
    logic [15:0]       pmem_addr;
    logic [15:0]       pc;
  } rsq_core_type;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } rsq_axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } rsq_axi_rsp_type;

endpackage

// ===== src/rsq_top.sv
// reset sequencer with cause flags and axi4-lite register slave
// assumes inputs synchronous to clock_i, memory data one cycle
// after pmem_addr_o, and software reading cause before it
// acknowledges a watchdog interrupt
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps

module rsq_top #(
  parameter int XTAL_HOLD_CYC = rsq_pkg::XTAL_HOLD_DEF
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_n_i,
  input  wire rsq_pkg::rsq_src_type     src_i,
  input  wire logic [7:0]               pmem_data_i,
  input  wire rsq_pkg::rsq_axi_req_type axi_i,
  output rsq_pkg::rsq_axi_rsp_type      axi_o,
  output rsq_pkg::rsq_core_type         core_o,
  output logic                          irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    rsq_pkg::rsq_phase_type         st;
    logic [rsq_pkg::CNT_W-1:0]      cnt;
    logic [rsq_pkg::CNT_W-1:0]      age;
    logic                           kind_por;
    rsq_pkg::rsq_src_type           s1;
    rsq_pkg::rsq_src_type           s2;
    rsq_pkg::rsq_src_type           s3;
    logic [7:0]                     cause;
    logic                           xtal_en;
    logic [rsq_pkg::EV_W-1:0]       ists;
    logic [rsq_pkg::EV_W-1:0]       imsk;
    logic                           irq;
    logic [7:0]                     pc_hi;
    rsq_pkg::rsq_core_type          core;
    logic                           awgot;
    logic [rsq_pkg::AXI_AW-1:0]     awaddr;
    logic                           wgot;
    logic [7:0]                     wdata;
    logic                           wstrb0;
    rsq_pkg::rsq_axi_rsp_type       rsp;
  } rsq_regs_type;

  rsq_regs_type r_reg;
  rsq_regs_type r_next;

  logic pin_fall;
  logic wdt_rise;
  logic stop_rise;
  logic sys_rst;
  logic stop_only;
  logic restart;
  logic rd_cause;
  logic any_set;

  function automatic logic last_cyc(
    input logic [rsq_pkg::CNT_W-1:0] c,
    input int unsigned               n
  );
    return c == rsq_pkg::CNT_W'(n - 1);
  endfunction

  function automatic logic is_mapped(
    input logic [rsq_pkg::AXI_AW-1:0] a
  );
    return a == rsq_pkg::CAUSE_OFS || a == rsq_pkg::CFG_OFS ||
           a == rsq_pkg::ISTS_OFS  || a == rsq_pkg::IMSK_OFS;
  endfunction

  assign axi_o  = r_reg.rsp;
  assign core_o = r_reg.core;
  assign irq_o  = r_reg.irq;

  // ==========================================================
  // next state
  always_comb begin
    logic                       aw_hs;
    logic                       w_hs;
    logic                       do_wr;
    logic [rsq_pkg::AXI_AW-1:0] wa;
    logic [7:0]                 wd;
    logic                       go_vec;
    logic [rsq_pkg::EV_W-1:0]   ev;
    logic [7:0]                 set_c;
    logic [7:0]                 clr_c;
    aw_hs  = 1'b0;
    w_hs   = 1'b0;
    do_wr  = 1'b0;
    wa     = '0;
    wd     = '0;
    go_vec = 1'b0;
    ev     = '0;
    set_c  = '0;
    clr_c  = '0;
    r_next = r_reg;

    r_next.s1 = src_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;

    pin_fall  = r_reg.s3.pin_rst_n & ~r_reg.s2.pin_rst_n;
    wdt_rise  = r_reg.s2.wdt_to & ~r_reg.s3.wdt_to;
    stop_rise = r_reg.s2.stop_rec & ~r_reg.s3.stop_rec;
    // por and lvd are levels: the sequence restarts while they last
    sys_rst   = r_reg.s2.por | r_reg.s2.lvd | wdt_rise | pin_fall;
    stop_only = stop_rise & ~sys_rst;
    restart   = sys_rst | stop_only;

    r_next.core.ctrl_load    = 1'b0;
    r_next.core.wdt_osc_load = 1'b0;
    r_next.core.clk_sel_rc   = 1'b0;

    if (restart) begin
      r_next.st            = rsq_pkg::ST_START;
      r_next.cnt           = '0;
      r_next.kind_por      = r_reg.s2.por | r_reg.s2.lvd;
      r_next.core.cpu_rst_n = 1'b0;
      r_next.core.cpu_run  = 1'b0;
      r_next.core.pmem_rd  = 1'b0;
      r_next.core.periph_idle = 1'b1;
      r_next.core.gpio_park = 1'b1;
      r_next.core.ctrl_load = sys_rst;
      r_next.core.clk_sel_rc = sys_rst;
      r_next.core.wdt_osc_load = 1'b1;
    end else begin
      unique case (r_reg.st)
        rsq_pkg::ST_START: begin
          if (last_cyc(r_reg.cnt, rsq_pkg::OSC_START_CYC)) begin
            r_next.cnt = '0;
            r_next.st  = r_reg.kind_por ? rsq_pkg::ST_SUPPLY
                                        : rsq_pkg::ST_HOLD;
          end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
        rsq_pkg::ST_SUPPLY: begin
          if (r_reg.s2.supply_ok) begin
            r_next.st = rsq_pkg::ST_HOLD;
          end
        end
        rsq_pkg::ST_HOLD: begin
          if (last_cyc(r_reg.cnt, r_reg.xtal_en ? XTAL_HOLD_CYC
                                              : rsq_pkg::HOLD_CYC))
          begin
            r_next.cnt = '0;
            if (!r_reg.s2.pin_rst_n) begin
              r_next.st = rsq_pkg::ST_PINW;
            end else begin
              go_vec = 1'b1;
            end
          end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
        rsq_pkg::ST_PINW: begin
          go_vec = r_reg.s2.pin_rst_n;
        end
        rsq_pkg::ST_VHI: begin
          r_next.st             = rsq_pkg::ST_VLO;
          r_next.core.pmem_addr = rsq_pkg::VEC_LO_ADDR;
        end
        rsq_pkg::ST_VLO: begin
          r_next.st           = rsq_pkg::ST_LOAD;
          r_next.pc_hi        = pmem_data_i;
          r_next.core.pmem_rd = 1'b0;
        end
        rsq_pkg::ST_LOAD: begin
          r_next.st           = rsq_pkg::ST_RUN;
          r_next.core.pc      = {r_reg.pc_hi, pmem_data_i};
          r_next.core.cpu_run = 1'b1;
          ev[rsq_pkg::EV_REL] = 1'b1;
        end
        rsq_pkg::ST_RUN: begin
          r_next.st = rsq_pkg::ST_RUN;
        end
      endcase
    end

    if (go_vec) begin
      r_next.st               = rsq_pkg::ST_VHI;
      r_next.core.cpu_rst_n   = 1'b1;
      r_next.core.periph_idle = 1'b0;
      r_next.core.gpio_park   = 1'b0;
      r_next.core.pmem_rd     = 1'b1;
      r_next.core.pmem_addr   = rsq_pkg::VEC_HI_ADDR;
    end

    // age only feeds the checks below
    if (restart || r_next.st != r_reg.st) begin
      r_next.age = '0;
    end else if (r_reg.age != '1) begin
      r_next.age = r_reg.age + 1'b1;
    end

    // ========================================================
    // axi4-lite slave
    aw_hs = axi_i.awvalid & r_reg.rsp.awready;
    w_hs  = axi_i.wvalid & r_reg.rsp.wready;
    if (aw_hs) begin
      r_next.awgot  = 1'b1;
      r_next.awaddr = axi_i.awaddr;
    end
    if (w_hs) begin
      r_next.wgot   = 1'b1;
      r_next.wdata  = axi_i.wdata[7:0];
      r_next.wstrb0 = axi_i.wstrb[0];
    end
    wa    = r_reg.awgot ? r_reg.awaddr : axi_i.awaddr;
    wd    = r_reg.wgot ? r_reg.wdata : axi_i.wdata[7:0];
    do_wr = (r_reg.awgot | aw_hs) & (r_reg.wgot | w_hs) &
            ~r_reg.rsp.bvalid;
    if (r_reg.rsp.bvalid && axi_i.bready) begin
      r_next.rsp.bvalid = 1'b0;
    end
    if (do_wr) begin
      r_next.awgot      = 1'b0;
      r_next.wgot       = 1'b0;
      r_next.rsp.bvalid = 1'b1;
      r_next.rsp.bresp  = is_mapped(wa) ? rsq_pkg::RESP_OKAY
                                        : rsq_pkg::RESP_SLVERR;
    end
    // only byte lane 0 holds bits
    if (do_wr && (r_reg.wgot ? r_reg.wstrb0 : axi_i.wstrb[0])) begin
      if (wa == rsq_pkg::CFG_OFS) begin
        r_next.xtal_en = wd[rsq_pkg::XTAL_BIT];
      end
      if (wa == rsq_pkg::IMSK_OFS) begin
        r_next.imsk = wd[rsq_pkg::EV_W-1:0];
      end
    end
    r_next.rsp.awready = ~r_next.awgot & ~r_next.rsp.bvalid;
    r_next.rsp.wready  = ~r_next.wgot & ~r_next.rsp.bvalid;

    rd_cause = 1'b0;
    if (r_reg.rsp.rvalid && axi_i.rready) begin
      r_next.rsp.rvalid = 1'b0;
    end
    if (axi_i.arvalid && r_reg.rsp.arready) begin
      r_next.rsp.rvalid = 1'b1;
      r_next.rsp.rresp  = is_mapped(axi_i.araddr) ?
                          rsq_pkg::RESP_OKAY : rsq_pkg::RESP_SLVERR;
      r_next.rsp.rdata  = '0;
      unique case (axi_i.araddr)
        rsq_pkg::CAUSE_OFS: begin
          r_next.rsp.rdata[7:0] = r_reg.cause;
          rd_cause = 1'b1;
        end
        rsq_pkg::CFG_OFS:
          r_next.rsp.rdata[rsq_pkg::XTAL_BIT] = r_reg.xtal_en;
        rsq_pkg::ISTS_OFS:
          r_next.rsp.rdata[rsq_pkg::EV_W-1:0] = r_reg.ists;
        rsq_pkg::IMSK_OFS:
          r_next.rsp.rdata[rsq_pkg::EV_W-1:0] = r_reg.imsk;
        default: r_next.rsp.rdata = '0;
      endcase
    end
    r_next.rsp.arready = ~r_next.rsp.rvalid;

    // ========================================================
    // cause flags; a set in the clearing cycle wins
    // stop recovery flag
    set_c[rsq_pkg::STOP_BIT] = stop_rise;
    clr_c[rsq_pkg::STOP_BIT] = r_reg.s2.por | wdt_rise | rd_cause;
    set_c[rsq_pkg::WDT_BIT] = wdt_rise |
                              (stop_rise & r_reg.s2.stop_by_wdt);
    clr_c[rsq_pkg::WDT_BIT] = r_reg.s2.por | rd_cause |
                              (stop_rise & r_reg.s2.stop_by_pin);
    set_c[rsq_pkg::EXT_BIT] = pin_fall;
    clr_c[rsq_pkg::EXT_BIT] = clr_c[rsq_pkg::WDT_BIT];
    any_set      = |set_c;
    r_next.cause = set_c | (r_reg.cause & ~clr_c);

    // ========================================================
    // interrupt status, write one to clear, set wins
    ev[rsq_pkg::EV_WDT]  = set_c[rsq_pkg::WDT_BIT];
    ev[rsq_pkg::EV_PIN]  = pin_fall;
    ev[rsq_pkg::EV_STOP] = stop_rise;
    if (do_wr && wa == rsq_pkg::ISTS_OFS &&
        (r_reg.wgot ? r_reg.wstrb0 : axi_i.wstrb[0])) begin
      r_next.ists = r_reg.ists & ~wd[rsq_pkg::EV_W-1:0];
    end
    r_next.ists = r_next.ists | ev;
    r_next.irq  = |(r_next.ists & r_next.imsk);
  end

  // ==========================================================
  // register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      r_reg                   <= '0;
      r_reg.st                <= rsq_pkg::ST_START;
      r_reg.kind_por          <= 1'b1;
      r_reg.s1                <= rsq_pkg::SRC_IDLE;
      r_reg.s2                <= rsq_pkg::SRC_IDLE;
      r_reg.s3                <= rsq_pkg::SRC_IDLE;
      r_reg.core.periph_idle  <= 1'b1;
      r_reg.core.gpio_park    <= 1'b1;
      r_reg.rsp.awready       <= 1'b1;
      r_reg.rsp.wready        <= 1'b1;
      r_reg.rsp.arready       <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // checks
  sequence s_start_done;
    r_reg.st == rsq_pkg::ST_START && !restart ##1
    r_reg.st inside {rsq_pkg::ST_SUPPLY, rsq_pkg::ST_HOLD};
  endsequence

  sequence s_hold_done(x);
    r_reg.st == rsq_pkg::ST_HOLD && r_reg.xtal_en == x && !restart
    ##1 r_reg.st inside {rsq_pkg::ST_VHI, rsq_pkg::ST_PINW};
  endsequence

  sequence s_vec;
    r_reg.st == rsq_pkg::ST_VHI ##1 r_reg.st == rsq_pkg::ST_VLO
    ##1 r_reg.st == rsq_pkg::ST_LOAD;
  endsequence

  a_osc_start_len: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_start_done |-> $past(r_reg.age) == rsq_pkg::OSC_START_CYC - 1)
    else $error("start-up interval length wrong");

  a_hold_short: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_hold_done(1'b0) |-> $past(r_reg.age) == rsq_pkg::HOLD_CYC - 1)
    else $error("short hold length wrong");

  a_hold_xtal: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_hold_done(1'b1) |-> $past(r_reg.age) == XTAL_HOLD_CYC - 1)
    else $error("crystal hold length wrong");

  a_supply_wait: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    r_reg.st == rsq_pkg::ST_SUPPLY && !r_reg.s2.supply_ok && !restart
    |=> r_reg.st == rsq_pkg::ST_SUPPLY && !core_o.cpu_rst_n)
    else $error("hold began before supply good");

  a_pin_holds: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    r_reg.st == rsq_pkg::ST_PINW && !r_reg.s2.pin_rst_n && !restart
    |=> r_reg.st == rsq_pkg::ST_PINW && !core_o.cpu_rst_n)
    else $error("released while pin asserted");

  a_gpio_park: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    restart |=> core_o.gpio_park && core_o.periph_idle
                && !core_o.cpu_rst_n)
    else $error("gpio not parked at reset");

  a_sys_load: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    sys_rst |=> core_o.ctrl_load && core_o.clk_sel_rc
                ##1 (!core_o.ctrl_load || $past(sys_rst)))
    else $error("system reset load pulse wrong");

  a_stop_keep: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    stop_only |=> core_o.wdt_osc_load && !core_o.ctrl_load
                  && !core_o.clk_sel_rc)
    else $error("stop recovery reloaded registers");

  a_vector_load: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_vec |=> core_o.cpu_run &&
      core_o.pc == {$past(pmem_data_i, 2), $past(pmem_data_i)})
    else $error("reset vector not loaded");

  a_stop_flag: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    stop_rise |=> r_reg.cause[rsq_pkg::STOP_BIT])
    else $error("stop flag not set");

  a_read_clear: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_cause && !any_set |=> r_reg.cause == 8'h00)
    else $error("cause read did not clear");

  a_pin_wake: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    stop_rise && r_reg.s2.stop_by_pin && !r_reg.s2.stop_by_wdt
    && !wdt_rise && !pin_fall
    |=> !r_reg.cause[rsq_pkg::WDT_BIT] && !r_reg.cause[rsq_pkg::EXT_BIT])
    else $error("pin wake left flags set");

  a_pin_flag: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    pin_fall |=> r_reg.cause[rsq_pkg::EXT_BIT] && !core_o.cpu_rst_n)
    else $error("pin reset flag not set");

endmodule

// ===== verif/rsq_partner.sv
// supply monitor and program memory beside the reset sequencer
// assumes the bench puts the wanted request levels on req_i
`timescale 1ns/1ps

module rsq_partner #(
  parameter int         SUP_DLY = 200,
  parameter logic [7:0] VEC_HI  = 8'h12,
  parameter logic [7:0] VEC_LO  = 8'h34
) (
  input  wire logic                 clock_i,
  input  wire rsq_pkg::rsq_src_type req_i,
  input  wire logic [15:0]          pmem_addr_i,
  output rsq_pkg::rsq_src_type      src_o,
  output logic [7:0]                pmem_data_o
);
  // ==========================================================
  // supply monitor
  int unsigned ramp = 0;

  // slow ramp so the sequencer must wait for it
  always @(posedge clock_i) begin
    if (req_i.por || req_i.lvd) begin
      ramp <= 0;
    end else if (ramp < SUP_DLY) begin
      ramp <= ramp + 1;
    end
  end

  always_comb begin
    src_o           = req_i;
    src_o.supply_ok = (ramp >= SUP_DLY);
  end

  // ==========================================================
  // program memory
  // other addresses give a changing pattern, never a stale byte
  always @(posedge clock_i) begin
    if (pmem_addr_i == rsq_pkg::VEC_HI_ADDR) begin
      pmem_data_o <= VEC_HI;
    end else if (pmem_addr_i == rsq_pkg::VEC_LO_ADDR) begin
      pmem_data_o <= VEC_LO;
    end else begin
      pmem_data_o <= ~pmem_addr_i[7:0];
    end
  end
endmodule

// ===== verif/rsq_top_tb.sv
// self-checking bench for the reset sequencer
// assumes rsq_partner as supply and memory, crystal hold shortened to 100
`timescale 1ns/1ps

module rsq_top_tb;
  logic                     clock_i = 1'b0;
  logic                     rst_n_i = 1'b0;
  rsq_pkg::rsq_src_type     req     = rsq_pkg::SRC_IDLE;
  rsq_pkg::rsq_src_type     src;
  logic [7:0]               pmem;
  rsq_pkg::rsq_axi_req_type axi_i   = '0;
  rsq_pkg::rsq_axi_rsp_type axi_o;
  rsq_pkg::rsq_core_type    core;
  logic                     irq_o;
  logic [31:0]              rd_d;
  logic [1:0]               rd_r;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int lo_cnt = 0;
  int lo_span = 0;
  int sup_cnt = 0;
  int sup_span = 0;
  int n_ctrl = 0;
  int n_wo = 0;
  int n_clk = 0;
  int c_ctrl;
  int c_wo;
  int c_clk;

  always #50 clock_i = ~clock_i;

  rsq_top #(.XTAL_HOLD_CYC(100)) rsq_top_i (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .src_i       (src),
    .pmem_data_i (pmem),
    .axi_i       (axi_i),
    .axi_o       (axi_o),
    .core_o      (core),
    .irq_o       (irq_o)
  );

  rsq_partner rsq_partner_i (
    .clock_i     (clock_i),
    .req_i       (req),
    .pmem_addr_i (core.pmem_addr),
    .src_o       (src),
    .pmem_data_o (pmem)
  );

  // ==========================================================
  // checks and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // monitor: reset spans, pulses, timeout
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    n_ctrl <= n_ctrl + int'(core.ctrl_load === 1'b1);
    n_wo <= n_wo + int'(core.wdt_osc_load === 1'b1);
    n_clk <= n_clk + int'(core.clk_sel_rc === 1'b1);
    if (core.cpu_rst_n === 1'b0) begin
      lo_cnt <= lo_cnt + 1;
      sup_cnt <= sup_cnt + int'(src.supply_ok);
      if (rst_n_i) begin
        chk({30'h0, core.gpio_park, core.periph_idle}, 32'h3);
      end
    end else if (lo_cnt != 0) begin
      lo_span <= lo_cnt;
      sup_span <= sup_cnt;
      lo_cnt <= 0;
      sup_cnt <= 0;
    end
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ==========================================================
  // axi4-lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    axi_i.awaddr <= a;
    axi_i.wdata <= d;
    axi_i.wstrb <= 4'hf;
    axi_i.awvalid <= 1'b1;
    axi_i.wvalid <= 1'b1;
    axi_i.bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (axi_i.awvalid && axi_o.awready) axi_i.awvalid <= 1'b0;
      if (axi_i.wvalid && axi_o.wready) axi_i.wvalid <= 1'b0;
    end while (axi_o.bvalid !== 1'b1);
    axi_i.bready <= 1'b0;
    chk({30'h0, axi_o.bresp}, {30'h0, rsq_pkg::RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    axi_i.araddr <= a;
    axi_i.arvalid <= 1'b1;
    axi_i.rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (axi_i.arvalid && axi_o.arready) axi_i.arvalid <= 1'b0;
    end while (axi_o.rvalid !== 1'b1);
    axi_i.rready <= 1'b0;
    rd_d = axi_o.rdata;
    rd_r = axi_o.rresp;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask

  // request held n cycles, then wait for the cpu to run again
  task automatic ev(input rsq_pkg::rsq_src_type v, input int n);
    int k;
    c_ctrl = n_ctrl;
    c_wo = n_wo;
    c_clk = n_clk;
    k = 0;
    @(posedge clock_i);
    req <= v;
    repeat (n) @(posedge clock_i);
    req <= rsq_pkg::SRC_IDLE;
    while (core.cpu_run !== 1'b0 && k < 50) begin
      @(posedge clock_i);
      k++;
    end
    while (core.cpu_run !== 1'b1 && k < 3000) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 3000) failures++;
    repeat (2) @(posedge clock_i);
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    ev(rsq_pkg::SRC_IDLE, 1);
    chk({16'h0, core.pc}, 32'h1234);
    chk({29'h0, core.pmem_rd, core.gpio_park, core.periph_idle}, 32'h0);
    rng(sup_span, 66, 74);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h0);
    rd(8'h40);
    chk({30'h0, rd_r}, {30'h0, rsq_pkg::RESP_SLVERR});
    ev(8'h00, 5);
    rng(lo_span, 106, 110);
    chk(32'(n_ctrl - c_ctrl), 32'h1);
    chk(32'(n_clk - c_clk), 32'h1);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h20);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h0);
    // pin held past the hold count
    ev(8'h00, 400);
    rng(lo_span, 398, 412);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h20);
    wr(rsq_pkg::IMSK_OFS, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(rsq_pkg::IMSK_OFS, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(rsq_pkg::IMSK_OFS, 32'h1);
    wr(rsq_pkg::ISTS_OFS, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    ev(8'h18, 5);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h40);
    wr(rsq_pkg::ISTS_OFS, 32'h2);
    // pin wake clears watchdog and pin flags
    ev(8'h18, 5);
    ev(8'h00, 5);
    ev(8'h16, 5);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h80);
    ev(8'h16, 5);
    ev(8'h18, 5);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h40);
    ev(8'h18, 5);
    ev(8'h90, 10);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h0);
    rng(sup_span, 66, 74);
    // low voltage waits for supply but keeps the flags
    ev(8'h18, 5);
    ev(8'h50, 10);
    rng(sup_span, 66, 74);
    rdchk(rsq_pkg::CAUSE_OFS, 32'h40);
    // crystal hold on a stop wake by watchdog
    wr(rsq_pkg::CFG_OFS, 32'h1);
    ev(8'h15, 5);
    rng(lo_span, 140, 146);
    chk(32'(n_ctrl - c_ctrl), 32'h0);
    chk(32'(n_wo - c_wo), 32'h1);
    rdchk(rsq_pkg::CAUSE_OFS, 32'hc0);
    results();
  end
endmodule
